// ==== core/cfgsel_pkg.sv ====
// constants for the configuration-select and reference-select block
// assumes a 100 MHz core clock and an outside register port for I2C writes
package cfgsel_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned T_BOOT_MS = 10;
   localparam int unsigned T_SETTLE_US = 1000;
   localparam int unsigned BOOT_CYC = T_BOOT_MS * 1000 * CLK_MHZ;
   localparam int unsigned SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
   localparam int unsigned STRAP_WAIT = 3;
   localparam int CNT_W = 24;

   localparam logic [7:0] REG_SRC_OFS = 8'h13;
   localparam logic [7:0] REG_SS_OFS = 8'h14;
   localparam logic [7:0] REG_SRC_RST = 8'h00;
   localparam logic [7:0] REG_SS_RST = 8'h00;
   localparam int PRIM_BIT = 1;
   localparam int SM_HI_BIT = 7;
   localparam int SS_EN_BIT = 7;
   localparam int SS_DOWN_BIT = 6;
   localparam logic [3:0] SS_STEP_MIN = 4'h1;
   localparam logic [3:0] SS_STEP_MAX = 4'ha;
   localparam logic [1:0] CFG_ZERO = 2'h0;

   typedef enum logic [3:0] {
      CS_SAMPLE = 4'h1,
      CS_LOAD = 4'h2,
      CS_SETTLE = 4'h4,
      CS_RUN = 4'h8
   } cfgsel_state_e;

   typedef enum logic [2:0] {
      RS_RUN = 3'h1,
      RS_DRAIN = 3'h2,
      RS_WAIT = 3'h4
   } cfgsel_sw_e;
endpackage

// ==== core/cfgsel_ref_switch.sv ====
// glitch-free selection between two synchronised reference levels
// assumes both references are already synchronised to i_clock
`timescale 1ns/1ns
`default_nettype none
module cfgsel_ref_switch
   import cfgsel_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_xtal,
   input wire logic i_diff,
   input wire logic i_sel,
   output logic o_ref,
   output logic o_cur_sel
);
   cfgsel_sw_e state_r, state_nxt;
   logic cur_r, cur_nxt;
   logic out_r, out_nxt;
   logic cur_lvl, new_lvl;

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      cur_lvl = cur_r ? i_diff : i_xtal;
      new_lvl = i_sel ? i_diff : i_xtal;
      state_nxt = state_r;
      cur_nxt = cur_r;
      out_nxt = out_r;
      case (state_r)
         RS_RUN:
         begin
            out_nxt = cur_lvl;
            if (i_sel != cur_r)
               state_nxt = RS_DRAIN;
         end
         // let current high phase finish, then hold low
         RS_DRAIN:
         begin
            out_nxt = out_r & cur_lvl;
            if (!cur_lvl)
               state_nxt = RS_WAIT;
         end
         RS_WAIT:
         begin
            out_nxt = 1'b0;
            if (!new_lvl)
            begin
               cur_nxt = i_sel;
               state_nxt = RS_RUN;
            end
         end
         default:
         begin
            state_nxt = RS_RUN;
            out_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         state_r <= RS_RUN;
         cur_r <= 1'b0;
         out_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         out_r <= out_nxt;
      end
   end

   assign o_ref = out_r;
   assign o_cur_sel = cur_r;

   ////////////////////////////////////////////////////////////////////
   no_rise_gap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state_r != RS_RUN) |=> !$rose(out_r))
      else $error("reference output rose during switchover");
endmodule
`default_nettype wire

// ==== core/cfgsel_top.sv ====
// power-up strap latch, configuration select and reference routing
// assumes a register port fed by an I2C slave outside this block
`timescale 1ns/1ns
`default_nettype none
module cfgsel_top
   import cfgsel_pkg::*;
#(
   parameter int unsigned BOOT_CYCLES = BOOT_CYC,
   parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_strap_refout_pin,
   output logic o_strap_refout_pin,
   output logic o_strap_refout_oe_n,
   input wire logic i_cfg_select_hi,
   input wire logic i_cfg_select_lo,
   input wire logic i_stored_default_flag,
   input wire logic i_ref_choose_pin,
   input wire logic i_crystal_ref_input,
   input wire logic i_diff_ref_input,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_i2c_enable,
   output logic o_cfg_load,
   output logic [1:0] o_cfg_index,
   output logic o_cfg_i2c_defaults,
   output logic o_cfg_busy,
   output logic o_ref_to_pll,
   output logic o_ref_is_diff,
   output logic o_ss_enable,
   output logic o_ss_down,
   output logic [3:0] o_ss_step
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by second
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;

   assign pin_raw = {i_strap_refout_pin, i_cfg_select_hi, i_cfg_select_lo,
      i_ref_choose_pin, i_crystal_ref_input, i_diff_ref_input};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++)
      begin : g_sync
         always_ff @(posedge i_clock)
         begin
            if (!i_rst_n)
            begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
            end
            else
            begin
               meta_r[g] <= pin_raw[g];
               sync_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   logic strap_s, sel_hi_s, sel_lo_s, choose_s, xtal_s, diff_s;
   assign {strap_s, sel_hi_s, sel_lo_s, choose_s, xtal_s, diff_s} = sync_r;

   ////////////////////////////////////////////////////////////////////
   // configuration sequencer
   cfgsel_state_e state_r, state_nxt;
   logic strap_r, strap_nxt;
   logic [1:0] code_r, code_nxt;
   logic [CNT_W-1:0] boot_r, boot_nxt;
   logic [CNT_W-1:0] wait_r, wait_nxt;
   logic load_r, load_nxt;
   logic i2cdef_r, i2cdef_nxt;
   logic boot_done;
   logic pin_change;

   assign boot_done = (boot_r >= CNT_W'(BOOT_CYCLES));
   assign pin_change = ({sel_hi_s, sel_lo_s} != code_r);

   always_comb
   begin
      state_nxt = state_r;
      strap_nxt = strap_r;
      code_nxt = code_r;
      wait_nxt = wait_r;
      load_nxt = 1'b0;
      i2cdef_nxt = i2cdef_r;
      boot_nxt = boot_done ? boot_r : boot_r + 1'b1;
      case (state_r)
         CS_SAMPLE:
         begin
            wait_nxt = wait_r + 1'b1;
            if (wait_r == CNT_W'(STRAP_WAIT))
            begin
               strap_nxt = strap_s;
               state_nxt = CS_LOAD;
            end
         end
         CS_LOAD:
         begin
            load_nxt = 1'b1;
            wait_nxt = '0;
            if (strap_r)
            begin
               code_nxt = {sel_hi_s, sel_lo_s};
               i2cdef_nxt = 1'b0;
            end
            else
            begin
               code_nxt = CFG_ZERO;
               i2cdef_nxt = i_stored_default_flag;
            end
            state_nxt = CS_SETTLE;
         end
         CS_SETTLE:
         begin
            wait_nxt = wait_r + 1'b1;
            if (wait_r >= CNT_W'(SETTLE_CYCLES - 1))
               state_nxt = CS_RUN;
         end
         CS_RUN:
         begin
            // pin route only; strap low leaves changes to I2C
            if (strap_r && !i_stored_default_flag && boot_done && pin_change)
               state_nxt = CS_LOAD;
         end
         default:
         begin
            state_nxt = CS_SAMPLE;
         end
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         state_r <= CS_SAMPLE;
         strap_r <= 1'b0;
         code_r <= CFG_ZERO;
         boot_r <= '0;
         wait_r <= '0;
         load_r <= 1'b0;
         i2cdef_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         strap_r <= strap_nxt;
         code_r <= code_nxt;
         boot_r <= boot_nxt;
         wait_r <= wait_nxt;
         load_r <= load_nxt;
         i2cdef_r <= i2cdef_nxt;
      end
   end

   logic sampled;
   assign sampled = (state_r != CS_SAMPLE);

   ////////////////////////////////////////////////////////////////////
   // registers reached over the I2C port
   logic [7:0] src_r, src_nxt;
   logic [7:0] ss_r, ss_nxt;
   logic reg_ok;

   assign reg_ok = sampled && !strap_r;

   always_comb
   begin
      src_nxt = src_r;
      ss_nxt = ss_r;
      if (reg_ok && i_reg_wr && (i_reg_addr == REG_SRC_OFS))
         src_nxt = i_reg_wdata;
      if (reg_ok && i_reg_wr && (i_reg_addr == REG_SS_OFS))
         ss_nxt = i_reg_wdata;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         src_r <= REG_SRC_RST;
         ss_r <= REG_SS_RST;
      end
      else
      begin
         src_r <= src_nxt;
         ss_r <= ss_nxt;
      end
   end

   always_comb
   begin
      o_reg_rdata = 8'h00;
      if (reg_ok && (i_reg_addr == REG_SRC_OFS))
         o_reg_rdata = src_r;
      else if (reg_ok && (i_reg_addr == REG_SS_OFS))
         o_reg_rdata = ss_r;
   end

   ////////////////////////////////////////////////////////////////////
   // spread settings for the fractional output divider
   logic [3:0] step_raw;
   assign step_raw = ss_r[3:0];
   assign o_ss_enable = ss_r[SS_EN_BIT];
   assign o_ss_down = ss_r[SS_DOWN_BIT];
   // center 0.25% steps, down 0.5% steps, ten steps each
   assign o_ss_step = (step_raw < SS_STEP_MIN) ? SS_STEP_MIN :
      (step_raw > SS_STEP_MAX) ? SS_STEP_MAX : step_raw;

   ////////////////////////////////////////////////////////////////////
   // reference selection
   logic manual;
   logic want_diff;
   logic ref_lvl;
   logic refout_r, refout_nxt;

   assign manual = !src_r[SM_HI_BIT];
   assign want_diff = manual ? (src_r[PRIM_BIT] ^ choose_s) : src_r[PRIM_BIT];

   cfgsel_ref_switch u_switch (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_xtal(xtal_s),
      .i_diff(diff_s),
      .i_sel(want_diff),
      .o_ref(ref_lvl),
      .o_cur_sel(o_ref_is_diff)
   );

   always_comb
   begin
      refout_nxt = sampled ? ref_lvl : 1'b0;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
         refout_r <= 1'b0;
      else
         refout_r <= refout_nxt;
   end

   assign o_ref_to_pll = ref_lvl;
   assign o_strap_refout_pin = refout_r;
   assign o_strap_refout_oe_n = !sampled;
   assign o_i2c_enable = reg_ok;
   assign o_cfg_load = load_r;
   assign o_cfg_index = code_r;
   assign o_cfg_i2c_defaults = i2cdef_r;
   assign o_cfg_busy = (state_r != CS_RUN);

   ////////////////////////////////////////////////////////////////////
   sequence s_load;
      (state_r == CS_LOAD);
   endsequence

   sequence s_settle;
      (state_r == CS_SETTLE);
   endsequence

   strap_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      sampled && $past(sampled) |-> $stable(strap_r))
      else $error("strap latch changed after sampling");

   refout_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state_r == CS_SAMPLE) |-> o_strap_refout_oe_n)
      else $error("strap pin driven during sampling");

   cfg_code_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_load ##0 strap_r |=> o_cfg_load && !o_cfg_i2c_defaults
         && (o_cfg_index == $past({sel_hi_s, sel_lo_s})))
      else $error("loaded index differs from select pins");

   i2c_default_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_load ##0 !strap_r |=> o_cfg_index == CFG_ZERO
         && o_cfg_i2c_defaults == $past(i_stored_default_flag))
      else $error("wrong load for strap low");

   no_pin_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state_r == CS_RUN) && !strap_r |=> (state_r == CS_RUN))
      else $error("pin load while strap low");

   early_change_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state_r == CS_RUN) && !boot_done |=> (state_r == CS_RUN))
      else $error("select change honoured before boot time");

   settle_time_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(state_r == CS_SETTLE) |-> s_settle until (wait_r >= CNT_W'(SETTLE_CYCLES - 1)))
      else $error("settle window cut short");

   ref_select_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $changed(want_diff)
         |-> ##[1:24] (o_ref_is_diff == want_diff))
      else $error("reference routing differs from select");

   reg_bit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      reg_ok && i_reg_wr && i_reg_addr == REG_SRC_OFS
         |=> src_r[PRIM_BIT] == $past(i_reg_wdata[PRIM_BIT]))
      else $error("primary bit not written");

   mode_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !manual && $stable(src_r) |-> $stable(want_diff))
      else $error("choose pin used outside manual mode");

   ss_range_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_ss_step >= SS_STEP_MIN && o_ss_step <= SS_STEP_MAX)
      else $error("spread step out of range");
endmodule
`default_nettype wire

// ==== sim/cfgsel_host_model.sv ====
// host-side model: board strap, select-pin driver and two reference sources
// assumes the bench names the strap level and a target select code
`timescale 1ns/1ns
`default_nettype none
module cfgsel_host_model #(
   parameter int GAP = 40
)
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_strap_up,
   input wire logic i_pin_oe_n,
   input wire logic i_pin_out,
   input wire logic [1:0] i_want,
   output logic o_pin,
   output logic o_sel_hi,
   output logic o_sel_lo,
   output logic o_xtal,
   output logic o_diff,
   output logic o_idle
);
   logic [1:0] cur_r = 2'h0;
   int gap_r = 0;
   int ph_r = 0;
   // released pin falls to the board strap, pull-up or pull-down per i_strap_up
   assign o_pin = i_pin_oe_n ? i_strap_up : i_pin_out;
   assign {o_sel_hi, o_sel_lo} = cur_r;
   assign o_idle = (cur_r == i_want) && (gap_r == 0);
   assign o_xtal = (ph_r % 6) < 3;
   assign o_diff = (ph_r % 10) < 5;
   always @(posedge i_clock)
   begin
      ph_r <= ph_r + 1;
      if (!i_rst_n)
      begin
         cur_r <= i_want;
         gap_r <= 0;
      end
      else if (gap_r != 0)
         gap_r <= gap_r - 1;
      else if (cur_r != i_want)
      begin
         if (cur_r[1] != i_want[1])
            cur_r[1] <= i_want[1];
         else
            cur_r[0] <= i_want[0];
         gap_r <= GAP;
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the configuration and reference selector
// assumes the host model on the far side; short boot and settle counts
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import cfgsel_pkg::*;
   localparam int unsigned BOOT = 200;
   localparam int unsigned SETL = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strap_up = 1'b0;
   logic flag = 1'b0;
   logic choose = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [1:0] want = 2'h0;
   logic mode_sel = 1'b0;
   logic pin, pin_out, oe_n, sel_hi, sel_lo, xtal, diff, idle, e;
   logic i2c_en, load, dflt, busy, ref_pll, is_diff, ss_en, ss_dn;
   logic [7:0] rdata, d;
   logic [1:0] idx;
   logic [3:0] step;
   int err_count = 0;
   int n_compared = 0;
   int seed = 52;
   int n, x;
   int st[4] = '{0, 1, 10, 15};
   logic xq[$];
   logic dq[$];
   logic [7:0] src_m = 8'h00;
   logic exp_sel;
   logic last_sel = 1'b0;
   int hold = 0;

   always #5 clk = ~clk;

   cfgsel_top #(.BOOT_CYCLES(BOOT), .SETTLE_CYCLES(SETL)) u_cfgsel_top (
      .i_clock(clk), .i_rst_n(rst_n), .i_strap_refout_pin(pin),
      .o_strap_refout_pin(pin_out), .o_strap_refout_oe_n(oe_n),
      .i_cfg_select_hi(sel_hi), .i_cfg_select_lo(sel_lo),
      .i_stored_default_flag(flag), .i_ref_choose_pin(choose),
      .i_crystal_ref_input(xtal), .i_diff_ref_input(diff), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_i2c_enable(i2c_en), .o_cfg_load(load), .o_cfg_index(idx),
      .o_cfg_i2c_defaults(dflt), .o_cfg_busy(busy), .o_ref_to_pll(ref_pll),
      .o_ref_is_diff(is_diff), .o_ss_enable(ss_en), .o_ss_down(ss_dn),
      .o_ss_step(step));

   cfgsel_host_model u_cfgsel_host_model (
      .i_clock(clk), .i_rst_n(rst_n), .i_strap_up(strap_up), .i_pin_oe_n(oe_n),
      .i_pin_out(pin_out), .i_want(want), .o_pin(pin), .o_sel_hi(sel_hi),
      .o_sel_lo(sel_lo), .o_xtal(xtal), .o_diff(diff), .o_idle(idle));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= dv;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      @(negedge clk);
      chk(rdata, exp);
   endtask

   task automatic do_reset(input logic s, input logic f);
      @(posedge clk);
      rst_n <= 1'b0;
      strap_up <= s;
      flag <= f;
      mode_sel <= s;
      src_m = 8'h00;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(oe_n, 1'b1);
      chk(busy, 1'b1);
      @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic wait_load(input logic [1:0] ei, input logic ed);
      n = 0;
      while (load !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      chk(load, 1'b1);
      chk(idx, ei);
      chk(dflt, ed);
      repeat (SETL - 2) @(negedge clk);
      chk(busy, 1'b1);
      n = 0;
      while (busy !== 1'b0 && n < 10)
      begin
         @(negedge clk);
         n++;
      end
      chk(busy, 1'b0);
   endtask

   task automatic ref_case(input logic sm, input logic p, input logic c);
      reg_wr(REG_SRC_OFS, {sm, 5'h00, p, 1'b0});
      src_m = {sm, 5'h00, p, 1'b0};
      choose <= c;
      e = sm ? p : p ^ c;
      n = 0;
      while (is_diff !== e && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      chk(is_diff, e);
      reg_rd(REG_SRC_OFS, {sm, 5'h00, p, 1'b0});
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(negedge clk)
      if (load === 1'b1 && mode_sel)
         chk({sel_hi, sel_lo}, idx);

   // reference model: source history, three stages to the pll, four to the pin
   always @(negedge clk)
   begin
      xq.push_back(xtal);
      dq.push_back(diff);
      if (xq.size() > 5)
      begin
         void'(xq.pop_front());
         void'(dq.pop_front());
      end
      exp_sel = src_m[7] ? src_m[1] : (src_m[1] ^ choose);
      if (rst_n !== 1'b1 || exp_sel !== last_sel)
         hold = 0;
      else if (hold < 30)
         hold++;
      last_sel = exp_sel;
      if (hold >= 24 && xq.size() == 5)
      begin
         chk(ref_pll, exp_sel ? dq[1] : xq[1]);
         chk(pin_out, exp_sel ? dq[0] : xq[0]);
      end
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done;
   end

   initial
   begin
      want <= 2'($random(seed));
      do_reset(1'b1, 1'b0);
      wait_load(want, 1'b0);
      chk(oe_n, 1'b0);
      chk(i2c_en, 1'b0);
      reg_wr(REG_SRC_OFS, 8'h02);
      reg_rd(REG_SRC_OFS, 8'h00);
      want <= want ^ 2'h1;
      repeat (100)
      begin
         @(negedge clk);
         chk(load, 1'b0);
      end
      wait_load(want, 1'b0);
      repeat (4)
      begin
         want <= 2'($random(seed));
         repeat (2) @(negedge clk);
         n = 0;
         while (!(idle === 1'b1 && busy === 1'b0) && n < 300)
         begin
            @(negedge clk);
            n++;
         end
         chk(idle & ~busy, 1'b1);
         chk(idx, want);
      end
      do_reset(1'b0, 1'b1);
      wait_load(2'h0, 1'b1);
      chk(i2c_en, 1'b1);
      chk(is_diff, 1'b0);
      want <= ~want;
      repeat (260)
      begin
         @(negedge clk);
         chk(load, 1'b0);
      end
      for (int i = 0; i < 8; i++)
         ref_case(i[2], i[1], i[0]);
      for (int i = 0; i < 4; i++)
      begin
         d = {i[0], i[1], 2'h0, st[i][3:0]};
         reg_wr(REG_SS_OFS, d);
         @(negedge clk);
         x = (st[i] < 1) ? 1 : (st[i] > 10) ? 10 : st[i];
         chk(ss_en, d[7]);
         chk(ss_dn, d[6]);
         chk(step, x[3:0]);
      end
      reg_rd(8'h15, 8'h00);
      do_reset(1'b0, 1'b0);
      wait_load(2'h0, 1'b0);
      chk(oe_n, 1'b0);
      test_done;
   end
endmodule
`default_nettype wire
